// file: lsg_pkg.sv
// package: constants for the low-res graphics shading and io decode block
package lsg_pkg;
  // ==========================================================================
  // io decode windows
  localparam logic [9:0] LSG_MONO_LO   = 10'h3B0;
  localparam logic [9:0] LSG_MONO_HI   = 10'h3BB;
  localparam logic [9:0] LSG_MONO_ONE  = 10'h3BF;
  localparam logic [9:0] LSG_COLR_LO   = 10'h3D0;
  localparam logic [9:0] LSG_COLR_HI   = 10'h3DF;
  // ==========================================================================
  // palette selection for pixel values 1, 2, 3
  localparam logic [2:0] LSG_PAL_C1    = 3'h3;
  localparam logic [2:0] LSG_PAL_C2    = 3'h5;
  localparam logic [2:0] LSG_PAL_C3    = 3'h7;
  // ==========================================================================
  // shade codes
  localparam logic [3:0] LSG_SH_SOLID  = 4'h0;
  localparam logic [3:0] LSG_SH_Q1     = 4'h1;
  localparam logic [3:0] LSG_SH_Q2     = 4'h2;
  localparam logic [3:0] LSG_SH_Q3     = 4'h3;
  localparam logic [3:0] LSG_SH_T1     = 4'h4;
  localparam logic [3:0] LSG_SH_T2     = 4'h5;
  localparam logic [3:0] LSG_SH_SL_OR  = 4'h6;
  localparam logic [3:0] LSG_SH_SL     = 4'h7;
  localparam logic [3:0] LSG_SH_CK_OR1 = 4'h8;
  localparam logic [3:0] LSG_SH_CK_AND = 4'h9;
  localparam logic [3:0] LSG_SH_CK_OR2 = 4'hA;
  localparam logic [3:0] LSG_SH_CK     = 4'hB;
  localparam logic [3:0] LSG_SH_BS_OR1 = 4'hC;
  localparam logic [3:0] LSG_SH_BS_AND = 4'hD;
  localparam logic [3:0] LSG_SH_BS_OR2 = 4'hE;
  localparam logic [3:0] LSG_SH_BS     = 4'hF;
  // ==========================================================================
  // frame sequence lengths for duty patterns
  localparam logic [2:0] LSG_FR_LAST   = 3'h7;   // 8-frame sequence, last index
  localparam logic [2:0] LSG_FR3_LAST  = 3'h5;   // 6-frame sequence, last index
  localparam logic [1:0] LSG_RST_PIX   = 2'h0;
endpackage

// file: lsg_if.sv
// interface: shade request between scaler and shade unit
`timescale 1ns/1ps
interface lsg_shade_if;
  logic [3:0] code;   // shade code
  logic [1:0] px;     // panel column, low bits
  logic [1:0] py;     // panel line, low bits
  logic [2:0] fr;     // frame count in 8
  logic [2:0] fr3;    // frame count in 6
  logic       on;     // shading signal result
  modport req (output code, px, py, fr, fr3, input on);
  modport shd (input code, px, py, fr, fr3, output on);
endinterface

// file: lsg_shade.sv
// module: shading signal generator from a 4-bit shade code
`timescale 1ns/1ps
module lsg_shade (
  lsg_shade_if.shd s    // shade request and result
);
  logic pat_sl;
  logic pat_bs;
  logic pat_ck;
  logic t14;
  logic t12;
  logic t34;
  logic t13;
  logic t23;
  logic [2:0] t13_sum;

  // crosshatch patterns over a 4x4 cell; 1 means pixel stays on
  always_comb
  begin
    pat_ck = s.px[0] ^ s.py[0];
    pat_sl = (s.px + s.py) != 2'h3;
    pat_bs = s.px != s.py;
  end

  // time patterns: spatially staggered so q1, q2 and q3 light a quarter, half and three quarters of the cell per frame
  always_comb
  begin
    t14 = ({s.py[1:0]} + {s.px[1:0]}) == s.fr[1:0];
    t12 = (s.px[0] ^ s.py[0]) == s.fr[0];
    t34 = ({s.py[1:0]} + {s.px[1:0]}) != s.fr[1:0];
    // x/3 over a 4x2 cell: each dot is on in two of the six frames
    t13_sum = {2'b00, s.px[1]} + {2'b00, s.py[0]} + s.fr3;
    t13 = (t13_sum == 3'h0) || (t13_sum == 3'h3) || (t13_sum == 3'h6);
    t23 = !t13;
  end

  // combine pattern and time per the shade code
  always_comb
  begin
    case (s.code)
      lsg_pkg::LSG_SH_SOLID:  s.on = 1'b1;
      lsg_pkg::LSG_SH_Q1:     s.on = t14;
      lsg_pkg::LSG_SH_Q2:     s.on = t12;
      lsg_pkg::LSG_SH_Q3:     s.on = t34;
      lsg_pkg::LSG_SH_T1:     s.on = t13;
      lsg_pkg::LSG_SH_T2:     s.on = t23;
      lsg_pkg::LSG_SH_SL_OR:  s.on = pat_sl | t12;
      lsg_pkg::LSG_SH_SL:     s.on = pat_sl;
      lsg_pkg::LSG_SH_CK_OR1: s.on = pat_ck | t14;
      lsg_pkg::LSG_SH_CK_AND: s.on = pat_ck & t12;
      lsg_pkg::LSG_SH_CK_OR2: s.on = pat_ck | t12;
      lsg_pkg::LSG_SH_CK:     s.on = pat_ck;
      lsg_pkg::LSG_SH_BS_OR1: s.on = pat_bs | t14;
      lsg_pkg::LSG_SH_BS_AND: s.on = pat_bs & t12;
      lsg_pkg::LSG_SH_BS_OR2: s.on = pat_bs | t12;
      default:                s.on = pat_bs;
    endcase
  end
endmodule

// file: lsg_top.sv
// module: low-res graphics pixel scaler, shader and host io window decoder
`timescale 1ns/1ps
module lsg_top #(
  parameter int LINE_PX = 320   // logical pixels the line store holds
) (
  input  wire logic        clk_sys,      // 20 MHz system clock
  input  wire logic        rstn,         // async reset, active low
  input  wire logic [9:0]  sa,           // host address, low ten lines (pin)
  input  wire logic        aen,          // host address enable, high in dma (pin)
  input  wire logic        ior_n,        // host io read strobe, low active (pin)
  input  wire logic        iow_n,        // host io write strobe, low active (pin)
  output logic             io_sel,       // host io access inside a window
  output logic             io_mono,      // window hit is the monochrome window
  input  wire logic        line400,      // panel has 400 lines
  input  wire logic [15:0] pal_flat,     // palette shade codes 5,7: [15:12]=7,[11:8]=5
  input  wire logic [3:0]  pal3,         // shade code of palette 3
  input  wire logic        pix_valid,    // logical pixel offered
  output logic             pix_ready,    // logical pixel taken
  input  wire logic [1:0]  pix_val,      // two-bit logical pixel
  input  wire logic        line_end,     // last logical pixel of the line
  input  wire logic        frame_end,    // last line of the frame
  output logic             dot_valid,    // panel pixel out valid
  output logic             dot_on        // panel pixel, 1 = dark dot
);
  // ==========================================================================
  // elaboration check: store indices are nine bits and a line needs one pixel
  if (LINE_PX < 1 || LINE_PX > 512)
  begin : g_bad_line_px
    $error("LINE_PX must lie in 1..512");
  end

  // ==========================================================================
  // pin synchronisers: three stages, change taken when stages two and three agree
  logic [12:0] s1_reg;
  logic [12:0] s2_reg;
  logic [12:0] s3_reg;
  logic [12:0] pin_reg;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_reg  <= 13'h1C00;
      s2_reg  <= 13'h1C00;
      s3_reg  <= 13'h1C00;
      pin_reg <= 13'h1C00;
    end
    else
    begin
      s1_reg <= {iow_n, ior_n, aen, sa};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        pin_reg <= s3_reg;
    end
  end

  // ==========================================================================
  // panel-kind strap is a pin as well; same three-stage filter, so a
  // bouncing strap cannot flip the pass order half way through a line
  logic [2:0] l4_sync_reg;
  logic       l4_reg;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      l4_sync_reg <= 3'h0;
      l4_reg      <= 1'b0;
    end
    else
    begin
      l4_sync_reg <= {l4_sync_reg[1:0], line400};
      if (l4_sync_reg[1] == l4_sync_reg[2])
        l4_reg <= l4_sync_reg[2];
    end
  end

  // ==========================================================================
  // io window decode; only ten lines compared, dma cycles ignored
  logic [9:0] adr;
  logic       hit_mono;
  logic       hit_colr;
  logic       strobe;
  always_comb
  begin
    adr      = pin_reg[9:0];
    strobe   = !pin_reg[11] || !pin_reg[12];
    hit_mono = 1'b0;
    hit_colr = 1'b0;
    if (adr >= lsg_pkg::LSG_MONO_LO && adr <= lsg_pkg::LSG_MONO_HI)
      hit_mono = 1'b1;
    else if (adr == lsg_pkg::LSG_MONO_ONE)
      hit_mono = 1'b1;
    else if (adr >= lsg_pkg::LSG_COLR_LO && adr <= lsg_pkg::LSG_COLR_HI)
      hit_colr = 1'b1;
  end

  // registered select, qualified by address enable low
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      io_sel  <= 1'b0;
      io_mono <= 1'b0;
    end
    else
    begin
      io_sel  <= strobe && !pin_reg[10] && (hit_mono || hit_colr);
      io_mono <= strobe && !pin_reg[10] && hit_mono;
    end
  end

  // ==========================================================================
  // scaler: each logical pixel is issued twice across; on 400 lines each
  // logical line is drawn twice, replaying from a line store
  typedef enum logic [1:0] {LSG_S_LIVE, LSG_S_REPLAY} lsg_state_t;
  lsg_state_t  st_reg;
  logic        half_reg;          // second copy of the current pixel
  logic [1:0]  line_mem [0:LINE_PX-1];  // logical line kept for the repeat pass
  logic        end_mem  [0:LINE_PX-1];
  localparam logic [8:0] LAST_PX = 9'(LINE_PX - 1);
  logic [8:0]  wr_reg;
  logic [8:0]  rd_reg;
  logic [1:0]  cur_val;
  logic        cur_end;
  logic        fend_reg;
  logic [9:0]  px_reg;
  logic [9:0]  py_reg;
  logic [2:0]  fr_reg;
  logic [2:0]  fr3_reg;
  logic        step;
  logic        live;

  assign live      = st_reg == lsg_state_t'(LSG_S_LIVE);
  assign cur_val   = live ? pix_val : line_mem[rd_reg];
  // a line longer than the store is cut at the store's end on the repeat pass
  assign cur_end   = live ? line_end : (end_mem[rd_reg] || rd_reg == LAST_PX);
  assign step      = live ? pix_valid : 1'b1;
  assign pix_ready = live && half_reg;

  // line store written as pixels are taken
  always_ff @(posedge clk_sys)
  begin
    if (live && pix_valid && half_reg && wr_reg <= LAST_PX)
    begin
      line_mem[wr_reg] <= pix_val;
      end_mem[wr_reg]  <= line_end;
    end
  end

  // pass sequencing
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg   <= LSG_S_LIVE;
      half_reg <= 1'b0;
      wr_reg   <= 9'h000;
      rd_reg   <= 9'h000;
      fend_reg <= 1'b0;
      px_reg   <= 10'h000;
      py_reg   <= 10'h000;
      fr_reg   <= 3'h0;
      fr3_reg  <= 3'h0;
    end
    else if (step)
    begin
      half_reg <= !half_reg;
      px_reg   <= px_reg + 10'h001;
      if (half_reg)
      begin
        if (live && wr_reg < LAST_PX)
          wr_reg <= wr_reg + 9'h001;
        if (!live)
          rd_reg <= rd_reg + 9'h001;
        if (cur_end)
        begin
          px_reg <= 10'h000;
          py_reg <= py_reg + 10'h001;
          wr_reg <= 9'h000;
          rd_reg <= 9'h000;
          if (live)
            fend_reg <= frame_end;
          if (live && l4_reg)
            st_reg <= LSG_S_REPLAY;
          else
            st_reg <= LSG_S_LIVE;
          if ((live && !l4_reg && frame_end) || (!live && fend_reg))
          begin
            py_reg  <= 10'h000;
            fr_reg  <= fr_reg + 3'h1;
            fr3_reg <= (fr3_reg == lsg_pkg::LSG_FR3_LAST) ? 3'h0 : fr3_reg + 3'h1;
          end
        end
      end
    end
  end

  // ==========================================================================
  // palette pick and shading
  lsg_shade_if sif ();
  always_comb
  begin
    case (cur_val)
      2'h1:    sif.code = pal3;
      2'h2:    sif.code = pal_flat[11:8];
      default: sif.code = pal_flat[15:12];
    endcase
    sif.px  = px_reg[1:0];
    sif.py  = py_reg[1:0];
    sif.fr  = fr_reg;
    sif.fr3 = fr3_reg;
  end

  lsg_shade u_shade (
    .s (sif.shd)
  );

  // output dot: value zero is background (light), others dark when shade is on
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      dot_valid <= 1'b0;
      dot_on    <= 1'b0;
    end
    else
    begin
      dot_valid <= step;
      dot_on    <= step && (cur_val != lsg_pkg::LSG_RST_PIX) && sif.on;
    end
  end
endmodule

// file: lsg_properties.sv
// checker: port-level properties of the shading and io decode block
`timescale 1ns/1ps
module lsg_properties (
  input wire logic        clk_sys,   // clock
  input wire logic        rstn,      // reset, low
  input wire logic [9:0]  sa,        // host address
  input wire logic        aen,       // dma flag
  input wire logic        ior_n,     // read strobe
  input wire logic        iow_n,     // write strobe
  input wire logic        io_sel,    // window hit
  input wire logic        io_mono,   // mono hit
  input wire logic        line400,   // panel kind
  input wire logic [15:0] pal_flat,  // codes 5,7
  input wire logic [3:0]  pal3,      // code 3
  input wire logic        pix_valid, // pixel offered
  input wire logic        pix_ready, // pixel taken
  input wire logic [1:0]  pix_val,   // pixel
  input wire logic        line_end,  // line end
  input wire logic        frame_end, // frame end
  input wire logic        dot_valid, // dot out
  input wire logic        dot_on     // dark dot
);
  // ==========================================================
  // decoded helpers
  logic take;
  logic mono;
  logic colr;
  logic solid;
  assign take  = pix_valid && pix_ready;
  assign mono  = (sa >= 10'h3B0 && sa <= 10'h3BB) || sa == 10'h3BF;
  assign colr  = sa >= 10'h3D0 && sa <= 10'h3DF;
  assign solid = (pix_val == 2'h1 && pal3 == 4'h0)
              || (pix_val == 2'h2 && pal_flat[11:8] == 4'h0)
              || (pix_val == 2'h3 && pal_flat[15:12] == 4'h0);
  // ==========================================================
  // properties; six samples cover the three-flop pin sync
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_dma_blocked: assert property (aen[*6] |=> !io_sel)
    else $error("io_sel during dma");
  a_idle_nosel: assert property ((ior_n && iow_n)[*6] |=> !io_sel)
    else $error("io_sel without strobe");
  a_mono_hit: assert property ((!aen && !ior_n && mono && $stable(sa))[*6]
    |=> io_sel && io_mono) else $error("mono window missed");
  a_colr_hit: assert property ((!aen && !ior_n && colr && $stable(sa))[*6]
    |=> io_sel && !io_mono) else $error("colour window missed");
  a_window_miss: assert property ((!mono && !colr && $stable(sa))[*6] |=> !io_sel)
    else $error("io_sel outside windows");
  a_mono_sub: assert property (io_mono |-> io_sel)
    else $error("io_mono without io_sel");
  a_dot_pair: assert property (take |-> dot_valid ##1 dot_valid)
    else $error("pixel not two dots");
  a_zero_blank: assert property (take && pix_val == 2'h0 |-> !dot_on ##1 !dot_on)
    else $error("zero pixel dark");
  a_solid_dark: assert property (take && solid |-> dot_on ##1 dot_on)
    else $error("solid pixel not dark");
  c_mono: cover property (io_sel && io_mono);
  c_colr: cover property (io_sel && !io_mono);
  c_take400: cover property (take && line400);
endmodule

// file: lsg_panel_model.sv
// model: panel side that tallies offered dots and dark dots
`timescale 1ns/1ps
module lsg_panel_model (
  input  wire logic clk_sys,   // clock
  input  wire logic clr,       // clear tallies
  input  wire logic dot_valid, // dot offered
  input  wire logic dot_on,    // dot dark
  output int        n_dots,    // dots seen
  output int        n_dark     // dark dots seen
);
  // a panel shifts every offered dot, so it never stalls the block
  always_ff @(posedge clk_sys)
  begin
    if (clr)
    begin
      n_dots <= 0;
      n_dark <= 0;
    end
    else if (dot_valid)
    begin
      n_dots <= n_dots + 1;
      n_dark <= n_dark + int'(dot_on === 1'b1);
    end
  end
endmodule

// file: tb.sv
// testbench: io window decode and pixel scaling with shading
`timescale 1ns/1ps
module tb;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [9:0]  sa = 10'h000;
  logic        aen = 1'b0;
  logic        ior_n = 1'b1;
  logic        iow_n = 1'b1;
  logic        line400 = 1'b0;
  logic [15:0] pal_flat = 16'hB000;  // pixel 3 checkerboard, pixel 2 solid
  logic [3:0]  pal3 = 4'h0;          // pixel 1 solid
  logic        pix_valid = 1'b0;
  logic [1:0]  pix_val = 2'h0;
  logic        line_end = 1'b0;
  logic        frame_end = 1'b0;
  logic        clr = 1'b0;
  logic        io_sel, io_mono, pix_ready, dot_valid, dot_on;
  int          n_dots, n_dark;
  int          miscompares = 0;
  int          num_checks = 0;
  always #25 clk_sys = ~clk_sys;
  lsg_top i_lsg_top (.clk_sys(clk_sys), .rstn(rstn), .sa(sa), .aen(aen),
    .ior_n(ior_n), .iow_n(iow_n), .io_sel(io_sel), .io_mono(io_mono),
    .line400(line400), .pal_flat(pal_flat), .pal3(pal3), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_val(pix_val), .line_end(line_end),
    .frame_end(frame_end), .dot_valid(dot_valid), .dot_on(dot_on));
  lsg_panel_model i_lsg_panel_model (.clk_sys(clk_sys), .clr(clr),
    .dot_valid(dot_valid), .dot_on(dot_on), .n_dots(n_dots), .n_dark(n_dark));
  // ==========================================================
  // compare and closing
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // one host io cycle; exp is {io_sel, io_mono}
  task io_cycle(input logic [9:0] a, input logic dma, input logic wr, input logic [1:0] exp);
    @(posedge clk_sys);
    sa <= a;
    aen <= dma;
    ior_n <= wr;
    iow_n <= !wr;
    repeat (6) @(posedge clk_sys);
    // look at settled outputs, then release on the next rising edge
    @(negedge clk_sys);
    chk("io_sel", exp[1], io_sel);
    chk("io_mono", exp[0], io_mono);
    @(posedge clk_sys);
    ior_n <= 1'b1;
    iow_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("io_idle", 1'b0, io_sel);
  endtask
  // range window edges on both sides, the lone 3BF address alone, both strobes, and dma cycles
  task test_io;
    io_cycle(10'h3AF, 1'b0, 1'b0, 2'b00);
    io_cycle(10'h3B0, 1'b0, 1'b0, 2'b11);
    io_cycle(10'h3BB, 1'b0, 1'b1, 2'b11);
    io_cycle(10'h3BC, 1'b0, 1'b0, 2'b00);
    io_cycle(10'h3BF, 1'b0, 1'b1, 2'b11);
    io_cycle(10'h3CF, 1'b0, 1'b0, 2'b00);
    io_cycle(10'h3D0, 1'b0, 1'b1, 2'b10);
    io_cycle(10'h3DF, 1'b0, 1'b0, 2'b10);
    io_cycle(10'h3E0, 1'b0, 1'b0, 2'b00);
    io_cycle(10'h3D5, 1'b1, 1'b0, 2'b00);
    io_cycle(10'h3B4, 1'b1, 1'b1, 2'b00);
    $display("test io done");
  endtask
  // one line of pixels 0,1,2,3 under given panel and palette codes;
  // the tallies include any replayed line
  task test_pix(input logic l400, input logic [3:0] p3, input logic [15:0] p57,
                input logic fend, input int exp_dots, input int exp_dark);
    int k;
    int n;
    @(posedge clk_sys);
    line400 <= l400;
    pal3 <= p3;
    pal_flat <= p57;
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      pix_valid <= 1'b1;
      pix_val <= 2'(k);
      line_end <= (k == 3);
      frame_end <= fend && (k == 3);
      n = 0;
      do
        @(posedge clk_sys);
      while (pix_ready !== 1'b1 && n++ < 50);
    end
    pix_valid <= 1'b0;
    line_end <= 1'b0;
    frame_end <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk("dots", exp_dots, n_dots);
    chk("dark", exp_dark, n_dark);
    $display("test pixels done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    test_io;
    test_pix(1'b0, 4'h0, 16'hB000, 1'b0, 8, 5);
    test_pix(1'b1, 4'h0, 16'hB000, 1'b0, 16, 10);
    // panel line 3: backslash on pixel 1, slash on pixel 2; frame ends here
    test_pix(1'b0, 4'hF, 16'h0700, 1'b1, 8, 4);
    // second frame: one-third duty is off across this whole line
    test_pix(1'b0, 4'h0, 16'h4400, 1'b0, 8, 2);
    finish_test;
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    finish_test;
  end
endmodule
bind lsg_top lsg_properties i_lsg_properties (.clk_sys(clk_sys), .rstn(rstn),
  .sa(sa), .aen(aen), .ior_n(ior_n), .iow_n(iow_n), .io_sel(io_sel),
  .io_mono(io_mono), .line400(line400), .pal_flat(pal_flat), .pal3(pal3),
  .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_val(pix_val),
  .line_end(line_end), .frame_end(frame_end), .dot_valid(dot_valid),
  .dot_on(dot_on));
